// ==== src/gpmai_pkg.sv ====
package gpmai_pkg;
   localparam int unsigned PIN_W = 12;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned MASK_LSB = 2;
   localparam int unsigned MASK_MSB = 13;
   // data window spans offsets 0x0000..0x3FFC
   localparam logic [ADDR_W-1:0] DATA_WIN_LAST = 16'h3FFC;
   localparam logic [ADDR_W-1:0] PORT_DATA_FULL_MASK_OFS = 16'h3FFC;
   localparam logic [ADDR_W-1:0] DIR_OFS = 16'h8000;
   localparam logic [ADDR_W-1:0] SENSE_SELECT_OFS = 16'h8004;
   localparam logic [ADDR_W-1:0] BOTH_EDGE_OFS = 16'h8008;
   localparam logic [ADDR_W-1:0] EVENT_POL_OFS = 16'h800C;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 16'h8010;
   localparam logic [ADDR_W-1:0] RAW_STATUS_OFS = 16'h8014;
   localparam logic [ADDR_W-1:0] MASKED_STATUS_OFS = 16'h8018;
   localparam logic [ADDR_W-1:0] EDGE_DETECT_CLEAR_OFS = 16'h801C;
   localparam logic [PIN_W-1:0] CFG_RST = 12'h000;
   localparam logic [PIN_W-1:0] OUT_RST = 12'h000;
   localparam int unsigned IRQ_SYNC_STAGES = 2;
endpackage

// ==== src/gpmai_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpmai_sync2
   import gpmai_pkg::*;
#(
   parameter int unsigned W = PIN_W
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // level in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;
   // two stages; only the second stage reads the first
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end
   assign q = q_r;
endmodule // gpmai_sync2
`default_nettype wire

// ==== src/gpmai_irq_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpmai_irq_cell
   import gpmai_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // synchronised pin and configuration
   input wire logic pin_s,
   input wire logic pin_prev,
   input wire logic level_mode,
   input wire logic both_edges,
   input wire logic active_high,
   input wire logic clear,
   // raw status
   output logic raw
);
   logic edge_hit;
   logic latch_r;
   logic level_hit;
   // edge qualifies by polarity unless both edges are selected
   assign edge_hit = (pin_s != pin_prev) && (both_edges || (pin_s == active_high));
   assign level_hit = (pin_s == active_high);
   // edge set wins over a simultaneous clear so no event is lost
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         latch_r <= 1'b0;
      end else if (!level_mode && edge_hit) begin
         latch_r <= 1'b1;
      end else if (level_mode || clear) begin
         latch_r <= 1'b0;
      end
   end
   // level pins ignore the clear and follow the pin
   assign raw = level_mode ? level_hit : latch_r;
endmodule // gpmai_irq_cell
`default_nettype wire

// ==== src/gpmai_port.sv ====
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module gpmai_port
   import gpmai_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rdata,
   // port pins, three signals each
   input wire logic [PIN_W-1:0] port_pin_in,
   output logic [PIN_W-1:0] port_pin_out,
   output logic [PIN_W-1:0] port_pin_oe,
   // towards the vectored interrupt controller
   output logic [PIN_W-1:0] pin_irq,
   output logic port_combined_irq
);
   logic [PIN_W-1:0] port_output_bits_r;
   logic [PIN_W-1:0] dir_r;
   logic [PIN_W-1:0] sense_select_r;
   logic [PIN_W-1:0] both_edge_r;
   logic [PIN_W-1:0] event_pol_r;
   logic [PIN_W-1:0] irq_enable_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [PIN_W-1:0] pin_s;
   logic [PIN_W-1:0] pin_prev_r;
   logic [PIN_W-1:0] raw_st;
   logic [PIN_W-1:0] masked_st;
   logic [PIN_W-1:0] irq_sync;
   logic [PIN_W-1:0] addr_mask;
   logic [PIN_W-1:0] edge_clear_bits;
   logic data_hit;
   logic wr_data;
   logic wr_dir;
   logic wr_sense;
   logic wr_both;
   logic wr_pol;
   logic wr_ien;
   logic wr_clr;

   // address decode; data window is the whole lower 16 KB
   assign data_hit = (addr <= DATA_WIN_LAST) && (addr[1:0] == 2'b00);
   assign addr_mask = addr[MASK_MSB:MASK_LSB];
   assign wr_data = wr_en && data_hit;
   assign wr_dir = wr_en && (addr == DIR_OFS);
   assign wr_sense = wr_en && (addr == SENSE_SELECT_OFS);
   assign wr_both = wr_en && (addr == BOTH_EDGE_OFS);
   assign wr_pol = wr_en && (addr == EVENT_POL_OFS);
   assign wr_ien = wr_en && (addr == IRQ_ENABLE_OFS);
   assign wr_clr = wr_en && (addr == EDGE_DETECT_CLEAR_OFS);
   // only the low twelve bits are ever looked at
   assign edge_clear_bits = wr_clr ? wdata[PIN_W-1:0] : '0;

   // pins are asynchronous, so they pass two flops first
   gpmai_sync2 #(.W(PIN_W)) u_pin_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d(port_pin_in),
      .q(pin_s)
   );

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_prev_r <= '0;
      end else begin
         pin_prev_r <= pin_s;
      end
   end

   // masked data write: each bit under its own address bit
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               port_output_bits_r[gi] <= OUT_RST[gi];
            end else if (wr_data && addr_mask[gi]) begin
               port_output_bits_r[gi] <= wdata[gi];
            end
         end // bit held otherwise
         gpmai_irq_cell u_cell (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .pin_s(pin_s[gi]),
            .pin_prev(pin_prev_r[gi]),
            .level_mode(sense_select_r[gi]),
            .both_edges(both_edge_r[gi]),
            .active_high(event_pol_r[gi]),
            .clear(edge_clear_bits[gi]),
            .raw(raw_st[gi])
         );
      end
   endgenerate

   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dir_r <= CFG_RST;
         sense_select_r <= CFG_RST;
         both_edge_r <= CFG_RST;
         event_pol_r <= CFG_RST;
         irq_enable_r <= CFG_RST;
      end else begin
         if (wr_dir) dir_r <= wdata[PIN_W-1:0];
         if (wr_sense) sense_select_r <= wdata[PIN_W-1:0];
         if (wr_both) both_edge_r <= wdata[PIN_W-1:0];
         if (wr_pol) event_pol_r <= wdata[PIN_W-1:0];
         if (wr_ien) irq_enable_r <= wdata[PIN_W-1:0];
      end
   end

   assign masked_st = raw_st & irq_enable_r;

   // interrupt path adds two clocks; software must allow for it
   gpmai_sync2 #(.W(PIN_W)) u_irq_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d(masked_st),
      .q(irq_sync)
   );

   assign pin_irq = irq_sync;
   assign port_combined_irq = |irq_sync;
   assign port_pin_out = port_output_bits_r;
   assign port_pin_oe = dir_r;

   // read mux; clear register and unmapped offsets read zero
   always_comb begin
      rdata_nxt = '0;
      if (data_hit) begin
         rdata_nxt[PIN_W-1:0] = pin_s & addr_mask;
      end else begin
         case (addr)
            DIR_OFS: rdata_nxt[PIN_W-1:0] = dir_r;
            SENSE_SELECT_OFS: rdata_nxt[PIN_W-1:0] = sense_select_r;
            BOTH_EDGE_OFS: rdata_nxt[PIN_W-1:0] = both_edge_r;
            EVENT_POL_OFS: rdata_nxt[PIN_W-1:0] = event_pol_r;
            IRQ_ENABLE_OFS: rdata_nxt[PIN_W-1:0] = irq_enable_r;
            RAW_STATUS_OFS: rdata_nxt[PIN_W-1:0] = raw_st;
            MASKED_STATUS_OFS: rdata_nxt[PIN_W-1:0] = masked_st;
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else if (rd_en) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= '0;
      end
   end
   assign rdata = rdata_r;

   // checks
   sequence s_clr_edge(int k);
      wr_clr && wdata[k] && !sense_select_r[k];
   endsequence

   chk_clear_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_clr && wdata[0] && !sense_select_r[0] && !(pin_s[0] != pin_prev_r[0]))
      |=> !raw_st[0]) else $error("clear did not drop edge latch");
   chk_clear_rd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_en && addr == EDGE_DETECT_CLEAR_OFS) |=> rdata == '0)
      else $error("clear register read nonzero");
   chk_irq_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##2 (pin_irq == $past(masked_st, 2)))
      else $error("irq delay not two clocks");
   chk_write_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_data |=> port_pin_out == (($past(wdata[PIN_W-1:0]) & $past(addr_mask))
         | ($past(port_output_bits_r) & ~$past(addr_mask))))
      else $error("masked write wrong");
   chk_write_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_data |=> $stable(port_pin_out)) else $error("output changed without write");
   chk_read_and: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_en && data_hit) |=> rdata == {20'h00000, $past(pin_s) & $past(addr_mask)})
      else $error("masked read wrong");
   chk_full_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_en && addr == PORT_DATA_FULL_MASK_OFS) |=> rdata[PIN_W-1:0] == $past(pin_s))
      else $error("full mask read wrong");
   chk_level_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sense_select_r[0] |-> raw_st[0] == (pin_s[0] == event_pol_r[0]))
      else $error("level pin not following");
   chk_enable_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (irq_enable_r == '0) [*3] |-> !port_combined_irq)
      else $error("disabled pins raised irq");
endmodule // gpmai_port
`default_nettype wire

// ==== testbench/gpmai_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpmai_pin_model
   import gpmai_pkg::*;
(
   // levels set by outside circuitry
   input wire logic [PIN_W-1:0] ext_level,
   // port side
   input wire logic [PIN_W-1:0] port_pin_out,
   input wire logic [PIN_W-1:0] port_pin_oe,
   output logic [PIN_W-1:0] port_pin_in
);
   // a driven pin shows the port's own level, so reads see the output register
   assign port_pin_in = (port_pin_oe & port_pin_out) | (~port_pin_oe & ext_level);
endmodule // gpmai_pin_model
`default_nettype wire

// ==== testbench/test_gpio_masked_access_irq_clear.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_gpio_masked_access_irq_clear
   import gpmai_pkg::*;
();
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [PIN_W-1:0] ext_level = '0;
   logic [DATA_W-1:0] rdata;
   logic [PIN_W-1:0] port_pin_in, port_pin_out, port_pin_oe, pin_irq;
   logic port_combined_irq;
   logic [PIN_W-1:0] exp_out = '0;
   logic [ADDR_W-1:0] a;
   logic [DATA_W-1:0] d, got;
   int n_mismatch = 0;
   int tests_run = 0;

   // 40 MHz system clock
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   gpmai_port i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .port_pin_in(port_pin_in),
      .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .pin_irq(pin_irq),
      .port_combined_irq(port_combined_irq));
   gpmai_pin_model i_pins (.ext_level(ext_level), .port_pin_out(port_pin_out),
      .port_pin_oe(port_pin_oe), .port_pin_in(port_pin_in));

   // expected output register after a masked write
   function automatic logic [PIN_W-1:0] merge(input logic [PIN_W-1:0] old,
      input logic [DATA_W-1:0] v, input logic [ADDR_W-1:0] ad);
      return (old & ~ad[MASK_MSB:MASK_LSB]) | (v[PIN_W-1:0] & ad[MASK_MSB:MASK_LSB]);
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // one-cycle write strobe, dropped at the edge that takes it
   task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] v);
      @(posedge clk_sys);
      addr <= ad;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] ad);
      @(posedge clk_sys);
      addr <= ad;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 got = rdata;
   endtask
   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
      tests_run++;
      if (seen !== want) begin
         n_mismatch++;
         $display("wrong value at %0t ns: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic test_done();
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // hang guard, far beyond the normal run
   initial begin
      #1000000;
      n_mismatch++;
      test_done();
   end

   initial begin
      void'($urandom(19));
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      // masked writes, both window ends first, then random word offsets
      for (int k = 0; k < 24; k++) begin
         a = (k == 0) ? DATA_WIN_LAST : (k == 1) ? 16'h0000 : {2'b00, 12'($urandom), 2'b00};
         d = $urandom;
         wr(a, d);
         exp_out = merge(exp_out, d, a);
         #1 chk(32'(port_pin_out), 32'(exp_out));
      end
      // masked reads of outside pin levels
      for (int k = 0; k < 16; k++) begin
         ext_level <= 12'($urandom);
         a = (k == 0) ? DATA_WIN_LAST : {2'b00, 12'($urandom), 2'b00};
         cyc(3);
         rd(a);
         chk(got, 32'(ext_level & a[MASK_MSB:MASK_LSB]));
      end
      // full-mask offset, upper bits ignored, driven pins read back
      wr(DATA_WIN_LAST, 32'hFFFF_F5A5);
      wr(DIR_OFS, 32'h0000_0FFF);
      wr(EDGE_DETECT_CLEAR_OFS, 32'h0000_0FFF);
      cyc(3);
      rd(DATA_WIN_LAST);
      chk(got, 32'h0000_05A5);
      rd(EDGE_DETECT_CLEAR_OFS);
      chk(got, 32'h0000_0000);
      chk(32'(port_pin_out), 32'h0000_05A5);
      // interrupt set-up: rising/high, pin 1 level, pin 0 edge
      ext_level <= '0;
      wr(DIR_OFS, 32'h0000_0000);
      wr(EVENT_POL_OFS, 32'h0000_0FFF);
      wr(SENSE_SELECT_OFS, 32'h0000_0002);
      cyc(4);
      wr(EDGE_DETECT_CLEAR_OFS, 32'h0000_0FFF);
      wr(IRQ_ENABLE_OFS, 32'h0000_0003);
      cyc(4);
      ext_level <= 12'h003;
      cyc(8);
      chk(32'({port_combined_irq, pin_irq}), 32'h0000_1003);
      ext_level <= 12'h002;
      wr(EDGE_DETECT_CLEAR_OFS, 32'hFFFF_F000);
      cyc(6);
      chk(32'(pin_irq), 32'h0000_0003);
      wr(EDGE_DETECT_CLEAR_OFS, 32'h0000_0003);
      // the handler idles two slots before leaving; the stale request shows for two more clocks
      cyc(1);
      #1 chk(32'(pin_irq), 32'h0000_0003);
      cyc(1);
      #1 chk(32'(pin_irq), 32'h0000_0002);
      // masking hides the level pin but not its raw status
      wr(IRQ_ENABLE_OFS, 32'h0000_0001);
      cyc(4);
      chk(32'({port_combined_irq, pin_irq}), 32'h0000_0000);
      rd(RAW_STATUS_OFS);
      chk(got, 32'h0000_0002);
      ext_level <= '0;
      cyc(4);
      rd(RAW_STATUS_OFS);
      chk(got, 32'h0000_0000);
      test_done();
   end
endmodule // test_gpio_masked_access_irq_clear
`default_nettype wire
